// *** core/sogr_pkg.sv ***
// Shared constants for the sensor output, offset and gain register bank
package sogr_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_FIRST_GAIN = 8'h10;
   localparam logic [7:0] IDX_OUT_DRIVE = 8'h12;
   localparam logic [7:0] IDX_COL_OFFSET = 8'h20;
   localparam logic [7:0] IDX_SECOND_GAIN = 8'h21;
   localparam logic [7:0] IDX_GAIN_MODE = 8'h22;
   localparam logic [7:0] IDX_COL_TABLE_LO = 8'h80;
   localparam logic [7:0] IDX_COL_TABLE_HI = 8'hbf;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int unsigned CODE_W = 6;
   localparam int unsigned MAG_W = 5;
   localparam int unsigned SIGN_BIT = 5;
   localparam int unsigned DRIVE_W = 2;
   localparam int unsigned BIT_SYNC_DRIVE = 1;
   localparam int unsigned BIT_PIX_DRIVE = 0;
   localparam int unsigned MODE_W = 2;
   localparam int unsigned MODE_LINEAR_MODE_TWO_BIT = 1;
   localparam int unsigned SUM_W = 7;
   localparam int unsigned PIX_W = 10;
   localparam int unsigned COL_W = 6;
   localparam int unsigned NUM_COLS = 64;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [DRIVE_W-1:0] RST_OUT_DRIVE = 2'h3;
   localparam logic [CODE_W-1:0] RST_FIRST_GAIN = 6'h0e;
   localparam logic [CODE_W-1:0] RST_SECOND_GAIN = 6'h0e;
   localparam logic [CODE_W-1:0] RST_COL_OFFSET = 6'h00;
   localparam logic [CODE_W-1:0] RST_COL_ENTRY = 6'h00;
   localparam logic [MODE_W-1:0] RST_GAIN_MODE = 2'h0;

   // Gain mode codes; any code with the upper bit set is linear mode two
   localparam logic [MODE_W-1:0] MODE_RAW = 2'h0;
   localparam logic [MODE_W-1:0] MODE_LINEAR_MODE_ONE = 2'h1;

   // Clip limits of the summed column offset
   localparam logic signed [SUM_W-1:0] OFFSET_CEIL = 7'sh20;
   localparam logic signed [SUM_W-1:0] OFFSET_FLOOR = 7'sh60;

endpackage

// *** core/sogr_col_offset.sv ***
// Saturating sum of the global and per-column sign-magnitude offsets
module sogr_col_offset
   import sogr_pkg::*;
(
   input wire logic [CODE_W-1:0] global_code,
   input wire logic [CODE_W-1:0] column_code,
   output logic signed [SUM_W-1:0] clipped_sum
);

   // ---------------------------------------------------------------
   // Sign-magnitude to two's complement
   // ---------------------------------------------------------------
   function automatic logic signed [SUM_W-1:0] to_signed
      (input logic [CODE_W-1:0] code);
      logic signed [SUM_W-1:0] mag;
      mag = signed'({2'b00, code[MAG_W-1:0]});
      if (code[SIGN_BIT])
      begin
         return -mag;
      end
      return mag;
   endfunction

   // Both operands lie in -31..31, so the raw sum fits seven bits
   wire logic signed [SUM_W-1:0] global_value = to_signed(global_code);
   wire logic signed [SUM_W-1:0] column_value = to_signed(column_code);
   wire logic signed [SUM_W-1:0] raw_sum = global_value + column_value; // [RQ5]
   wire logic over_ceil = raw_sum > OFFSET_CEIL;
   wire logic under_floor = raw_sum < OFFSET_FLOOR;

   assign clipped_sum = over_ceil ? OFFSET_CEIL :
                        (under_floor ? OFFSET_FLOOR : raw_sum); // [RQ6]

endmodule

// *** core/sogr_gain_route.sv ***
// Steers the two exposure gain codes onto the cascaded gain stages
module sogr_gain_route
   import sogr_pkg::*;
(
   input wire logic [MODE_W-1:0] gain_mode,
   input wire logic [CODE_W-1:0] first_gain_code,
   input wire logic [CODE_W-1:0] second_gain_code,
   output logic [CODE_W-1:0] stage_a_code,
   output logic [CODE_W-1:0] stage_b_code,
   output logic linear_mode_two
);

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   assign linear_mode_two = gain_mode[MODE_LINEAR_MODE_TWO_BIT];

   // Raw and linear mode one: two independent cascaded stages
   // Linear mode two: the second code is ignored and both stages
   // follow the first code, the analog side forms one linear step
   assign stage_a_code = first_gain_code; // [RQ11]
   assign stage_b_code = linear_mode_two ? first_gain_code
                                         : second_gain_code; // [RQ11] [RQ12]

endmodule

// *** core/sogr_regs.sv ***
// APB register bank for sensor output drive, column offset and gain
//
// Behaviour
// RQ1: Sync drive bit low floats the line, frame, pixel-valid and strobe pins.
// RQ2: Pixel drive bit low floats all pixel data pins, high drives them.
// RQ3: The output drive register resets to 03 hex, driving all outputs.
// RQ4: The column offset is sign-magnitude, bit 5 negative, bits 4..0 size.
// RQ5: Each column adds the global offset to its own correction entry.
// RQ6: The summed offset is clipped to plus or minus 32.
// RQ7: The column offset register resets to 00 hex, adding nothing.
// RQ8: Software should set the converter dark level elsewhere, not here.
// RQ9: Software calibrates the offset by matching dark level across gains.
// RQ10: The second gain field is six bits and applies to every pixel.
// RQ11: In raw and linear mode one the two gain codes drive separate stages.
// RQ12: In linear mode two the second code is ignored for both stages.
// RQ13: The second gain register resets to 0E hex, the unity code.
// RQ14: Software keeps gain codes within 0..47 in linear mode one.
// RQ15: Unused and factory bits ignore writes and read back as zero.
module sogr_regs
   import sogr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [COL_W-1:0] col_index,
   output logic signed [SUM_W-1:0] col_offset,
   output logic [CODE_W-1:0] stage_a_code,
   output logic [CODE_W-1:0] stage_b_code,
   output logic linear_mode_two,
   input wire logic line_sync_core,
   input wire logic frame_start_core,
   input wire logic pixel_valid_core,
   input wire logic strobe_core,
   input wire logic [PIX_W-1:0] pixel_core,
   output logic line_sync_out,
   output logic frame_start_out,
   output logic pixel_valid_out,
   output logic strobe_out,
   output logic sync_oe,
   output logic [PIX_W-1:0] pixel_out,
   output logic pixel_oe
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [DRIVE_W-1:0] output_drive_control;
   logic [CODE_W-1:0] column_offset_global;
   logic [CODE_W-1:0] exposure_gain_second;
   logic [CODE_W-1:0] exposure_gain_first;
   logic [MODE_W-1:0] gain_mode;
   logic [CODE_W-1:0] col_table [NUM_COLS];

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   wire logic [7:0] reg_index = paddr[ADDR_W-1:2];
   wire logic addr_aligned = (paddr[1:0] == 2'h0);
   wire logic hit_first_gain = addr_aligned & (reg_index == IDX_FIRST_GAIN);
   wire logic hit_out_drive = addr_aligned & (reg_index == IDX_OUT_DRIVE);
   wire logic hit_col_offset = addr_aligned & (reg_index == IDX_COL_OFFSET);
   wire logic hit_second_gain = addr_aligned
                                & (reg_index == IDX_SECOND_GAIN);
   wire logic hit_gain_mode = addr_aligned & (reg_index == IDX_GAIN_MODE);
   wire logic hit_col_table = addr_aligned
                              & (reg_index >= IDX_COL_TABLE_LO)
                              & (reg_index <= IDX_COL_TABLE_HI);
   wire logic addr_mapped = hit_first_gain | hit_out_drive | hit_col_offset
                            | hit_second_gain | hit_gain_mode | hit_col_table;
   wire logic [COL_W-1:0] table_slot = reg_index[COL_W-1:0];

   // ---------------------------------------------------------------
   // Bus phases
   // ---------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   wire logic setup_phase = psel & ~penable;
   wire logic access_phase = psel & penable;
   // All fields live in byte lane 0; a write without that lane is a no-op
   wire logic wr_en = access_phase & pwrite & addr_mapped & pstrb[0];
   wire logic rd_load = setup_phase & ~pwrite;
   wire logic [CODE_W-1:0] wdata_code = pwdata[CODE_W-1:0];
   wire logic [DRIVE_W-1:0] wdata_drive = pwdata[DRIVE_W-1:0];
   wire logic [MODE_W-1:0] wdata_mode = pwdata[MODE_W-1:0];

   assign pready = 1'b1;
   assign pslverr = access_phase & ~addr_mapped;

   // ---------------------------------------------------------------
   // Read selection
   // ---------------------------------------------------------------
   // Narrow fields are zero extended, so unused bits read as zero
   wire logic [DATA_W-1:0] rd_first = {{(DATA_W-CODE_W){1'b0}},
                                       exposure_gain_first};
   wire logic [DATA_W-1:0] rd_drive = {{(DATA_W-DRIVE_W){1'b0}},
                                       output_drive_control}; // [RQ15]
   wire logic [DATA_W-1:0] rd_offset = {{(DATA_W-CODE_W){1'b0}},
                                        column_offset_global}; // [RQ15]
   wire logic [DATA_W-1:0] rd_second = {{(DATA_W-CODE_W){1'b0}},
                                        exposure_gain_second}; // [RQ15]
   wire logic [DATA_W-1:0] rd_mode = {{(DATA_W-MODE_W){1'b0}}, gain_mode};
   wire logic [DATA_W-1:0] rd_table = {{(DATA_W-CODE_W){1'b0}},
                                       col_table[table_slot]};
   wire logic [DATA_W-1:0] read_value =
      hit_first_gain ? rd_first :
      hit_out_drive ? rd_drive :
      hit_col_offset ? rd_offset :
      hit_second_gain ? rd_second :
      hit_gain_mode ? rd_mode :
      hit_col_table ? rd_table : '0;

   // Read data is captured in the setup cycle so it leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (rd_load)
         prdata <= read_value;
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Factory bits above the two drive bits are never stored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         output_drive_control <= RST_OUT_DRIVE; // [RQ3]
      else if (wr_en && hit_out_drive)
         output_drive_control <= wdata_drive; // [RQ15]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         column_offset_global <= RST_COL_OFFSET; // [RQ7]
      else if (wr_en && hit_col_offset)
         column_offset_global <= wdata_code; // [RQ4]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         exposure_gain_second <= RST_SECOND_GAIN; // [RQ13]
      else if (wr_en && hit_second_gain)
         exposure_gain_second <= wdata_code; // [RQ10]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         exposure_gain_first <= RST_FIRST_GAIN;
      else if (wr_en && hit_first_gain)
         exposure_gain_first <= wdata_code;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gain_mode <= RST_GAIN_MODE;
      else if (wr_en && hit_gain_mode)
         gain_mode <= wdata_mode;
   end

   // ---------------------------------------------------------------
   // Per-column correction table
   // ---------------------------------------------------------------
   // Flops rather than RAM: the whole table must reset to zero
   for (genvar i = 0; i < NUM_COLS; i++)
   begin : g_col
      wire logic slot_wr = wr_en & hit_col_table
                           & (table_slot == COL_W'(i));
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            col_table[i] <= RST_COL_ENTRY;
         else if (slot_wr)
            col_table[i] <= wdata_code;
      end
   end

   // ---------------------------------------------------------------
   // Column offset path
   // ---------------------------------------------------------------
   wire logic [CODE_W-1:0] column_entry = col_table[col_index];
   wire logic signed [SUM_W-1:0] clipped_sum;

   sogr_col_offset u_col_offset (
      .global_code(column_offset_global),
      .column_code(column_entry),
      .clipped_sum(clipped_sum)
   );

   // One cycle of latency from col_index to col_offset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         col_offset <= '0;
      else
         col_offset <= clipped_sum; // [RQ5] [RQ6]
   end

   // ---------------------------------------------------------------
   // Gain stage routing
   // ---------------------------------------------------------------
   wire logic [CODE_W-1:0] next_stage_a;
   wire logic [CODE_W-1:0] next_stage_b;
   wire logic next_linear_two;

   sogr_gain_route u_gain_route (
      .gain_mode(gain_mode),
      .first_gain_code(exposure_gain_first),
      .second_gain_code(exposure_gain_second),
      .stage_a_code(next_stage_a),
      .stage_b_code(next_stage_b),
      .linear_mode_two(next_linear_two)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage_a_code <= RST_FIRST_GAIN;
         stage_b_code <= RST_SECOND_GAIN;
         linear_mode_two <= 1'b0;
      end
      else
      begin
         stage_a_code <= next_stage_a; // [RQ11]
         stage_b_code <= next_stage_b; // [RQ12]
         linear_mode_two <= next_linear_two;
      end
   end

   // ---------------------------------------------------------------
   // Output pins
   // ---------------------------------------------------------------
   // Enables come straight from the register so a bus share can take
   // effect one edge after the write, independent of the pixel stream
   assign sync_oe = output_drive_control[BIT_SYNC_DRIVE]; // [RQ1]
   assign pixel_oe = output_drive_control[BIT_PIX_DRIVE]; // [RQ2]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_sync_out <= 1'b0;
         frame_start_out <= 1'b0;
         pixel_valid_out <= 1'b0;
         strobe_out <= 1'b0;
         pixel_out <= '0;
      end
      else
      begin
         line_sync_out <= line_sync_core;
         frame_start_out <= frame_start_core;
         pixel_valid_out <= pixel_valid_core;
         strobe_out <= strobe_core;
         pixel_out <= pixel_core;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic past_first;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         past_first <= 1'b0;
      else
         past_first <= 1'b1;
   end

   a_sync_drive_write: assert property ( // [RQ1]
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_out_drive)
      |=> (sync_oe == $past(wdata_drive[BIT_SYNC_DRIVE])))
      else $error("sync enable does not follow written drive bit");

   a_pix_drive_write: assert property ( // [RQ2]
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_out_drive)
      |=> (pixel_oe == $past(wdata_drive[BIT_PIX_DRIVE])))
      else $error("pixel enable does not follow written drive bit");

   a_drive_reset_val: assert property ( // [RQ3]
      @(posedge pclk) disable iff (!presetn)
      !past_first |-> (sync_oe && pixel_oe && rd_drive == 32'h00000003))
      else $error("output drive register not 03 after reset");

   a_offset_negative: assert property ( // [RQ4]
      @(posedge pclk) disable iff (!presetn)
      (column_offset_global[SIGN_BIT] && column_entry == 6'h00)
      |=> (col_offset == -$signed({2'b00,
                                   $past(column_offset_global[MAG_W-1:0])})))
      else $error("negative global offset not applied as minus magnitude");

   a_offset_sum_pos: assert property ( // [RQ5]
      @(posedge pclk) disable iff (!presetn)
      (column_offset_global == 6'h00 && !column_entry[SIGN_BIT])
      |=> (col_offset == $signed({2'b00, $past(column_entry[MAG_W-1:0])})))
      else $error("column entry not passed through with zero global offset");

   a_offset_clip_range: assert property ( // [RQ6]
      @(posedge pclk) disable iff (!presetn)
      (col_offset <= OFFSET_CEIL) && (col_offset >= OFFSET_FLOOR))
      else $error("column offset outside plus or minus 32");

   a_offset_reset_zero: assert property ( // [RQ7]
      @(posedge pclk) disable iff (!presetn)
      !past_first |=> (col_offset == 7'sh00))
      else $error("column offset not zero after reset");

   a_second_gain_store: assert property ( // [RQ10]
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_second_gain)
      |=> (exposure_gain_second == $past(wdata_code)))
      else $error("second gain write not stored as six bits");

   a_gain_separate: assert property ( // [RQ11]
      @(posedge pclk) disable iff (!presetn)
      (gain_mode == MODE_RAW || gain_mode == MODE_LINEAR_MODE_ONE)
      |=> (stage_b_code == $past(exposure_gain_second)
           && stage_a_code == $past(exposure_gain_first)))
      else $error("gain stages not separate in raw or linear one");

   a_gain_linear_mode_two_ignore: assert property ( // [RQ12]
      @(posedge pclk) disable iff (!presetn)
      gain_mode[MODE_LINEAR_MODE_TWO_BIT]
      |=> (stage_b_code == $past(exposure_gain_first) && linear_mode_two))
      else $error("second gain not ignored in linear mode two");

   a_second_gain_reset: assert property ( // [RQ13]
      @(posedge pclk) disable iff (!presetn)
      !past_first |-> (exposure_gain_second == 6'h0e))
      else $error("second gain register not 0E after reset");

   a_unused_read_zero: assert property ( // [RQ15]
      @(posedge pclk) disable iff (!presetn)
      (rd_load && (hit_col_offset || hit_second_gain || hit_out_drive))
      |=> (prdata[DATA_W-1:CODE_W] == 26'h0000000))
      else $error("unused register bits did not read as zero");

endmodule

// *** bench/sogr_regs_tb.sv ***
// Self-checking bench for the output drive, offset and gain register bank
module sogr_regs_tb
   import sogr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Signals and design
   // ---------------------------------------------------------------
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [3:0] pstrb;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic [COL_W-1:0] col_index;
   logic signed [SUM_W-1:0] col_offset;
   logic [CODE_W-1:0] stage_a_code;
   logic [CODE_W-1:0] stage_b_code;
   logic linear_mode_two;
   logic [3:0] sync_core;
   logic [PIX_W-1:0] pixel_core;
   logic [3:0] sync_out;
   logic sync_oe;
   logic [PIX_W-1:0] pixel_out;
   logic pixel_oe;
   int fail_count;
   int cmp_count;

   sogr_regs u_sogr_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .col_index(col_index), .col_offset(col_offset),
      .stage_a_code(stage_a_code), .stage_b_code(stage_b_code),
      .linear_mode_two(linear_mode_two),
      .line_sync_core(sync_core[3]), .frame_start_core(sync_core[2]),
      .pixel_valid_core(sync_core[1]), .strobe_core(sync_core[0]),
      .pixel_core(pixel_core),
      .line_sync_out(sync_out[3]), .frame_start_out(sync_out[2]),
      .pixel_valid_out(sync_out[1]), .strobe_out(sync_out[0]),
      .sync_oe(sync_oe), .pixel_out(pixel_out), .pixel_oe(pixel_oe)
   );

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   // Waits for pready rather than assuming the zero-wait answer
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, idx, d, rd, err);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 32'h0, rd, err);
      chk(rd, exp, "read data");
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic [5:0] sm(input int v);
      return v < 0 ? {1'b1, 5'(-v)} : {1'b0, 5'(v)};
   endfunction

   function automatic int clip(input int s);
      return s > 32 ? 32 : (s < -32 ? -32 : s);
   endfunction

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      logic [31:0] rd;
      logic err;
      int ga[6] = '{31, -31, 5, -20, 0, -16};
      int ca[6] = '{31, -31, -3, 4, -31, -16};
      int ks[6] = '{0, 63, 17, 40, 1, 62};
      fail_count = 0;
      cmp_count = 0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = '0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      col_index = '0;
      sync_core = 4'h0;
      pixel_core = '0;
      tick(10);
      presetn <= 1'b1;
      tick(2);
      chk(32'({sync_oe, pixel_oe}), 32'h3, "drive reset");
      chk(32'(stage_b_code), 32'h0e, "stage b reset");
      chk(32'(col_offset), 32'h0, "offset reset");
      rchk(IDX_OUT_DRIVE, 32'h03);
      rchk(IDX_COL_OFFSET, 32'h00);
      rchk(IDX_SECOND_GAIN, 32'h0e);
      // Factory bits are written as ones on purpose
      for (int v = 0; v < 4; v++)
      begin
         wr(IDX_OUT_DRIVE, 32'hfc | v);
         tick(2);
         chk(32'(sync_oe), 32'(v >> 1), "sync enable");
         chk(32'(pixel_oe), 32'(v & 1), "pixel enable");
         rchk(IDX_OUT_DRIVE, 32'(v));
      end
      sync_core <= 4'hf;
      pixel_core <= 10'h2a5;
      tick(2);
      chk(32'(sync_out), 32'hf, "sync pins");
      chk(32'(pixel_out), 32'h2a5, "pixel pins");
      wr(IDX_COL_OFFSET, 32'hffff_ffd5);
      rchk(IDX_COL_OFFSET, 32'h15);
      wr(IDX_SECOND_GAIN, 32'hffff_ffc7);
      rchk(IDX_SECOND_GAIN, 32'h07);
      // Without byte lane 0 a write must leave the field alone
      pstrb <= 4'he;
      wr(IDX_SECOND_GAIN, 32'h3f);
      pstrb <= 4'hf;
      rchk(IDX_SECOND_GAIN, 32'h07);
      for (int i = 0; i < 6; i++)
      begin
         wr(IDX_COL_OFFSET, 32'(sm(ga[i])));
         wr(IDX_COL_TABLE_LO + 8'(ks[i]), 32'(sm(ca[i])));
         col_index <= 6'(ks[i]);
         tick(2);
         chk(32'(col_offset), 32'(clip(ga[i] + ca[i])),
             "sum");
      end
      // Calibration order: gain up first, then trim the global offset
      col_index <= 6'd5;
      wr(IDX_FIRST_GAIN, 32'h3f);
      wr(IDX_COL_OFFSET, 32'(sm(-9)));
      tick(2);
      chk(32'(col_offset), 32'(-9), "negative global");
      // The converter dark level register is not part of this bank
      apb(1'b1, 8'h23, 32'h17, rd, err);
      chk(32'(err), 32'h1, "dark level elsewhere");
      rchk(IDX_COL_OFFSET, 32'(sm(-9)));
      // Largest code software may use in linear mode one
      wr(IDX_FIRST_GAIN, 32'h2f);
      wr(IDX_SECOND_GAIN, 32'h2a);
      for (int m = 0; m < 4; m++)
      begin
         wr(IDX_GAIN_MODE, 32'(m));
         tick(2);
         chk(32'(stage_a_code), 32'h2f, "stage a");
         chk(32'(stage_b_code), m > 1 ? 32'h2f : 32'h2a,
             "stage b");
         chk(32'(linear_mode_two), 32'(m >> 1), "mode two");
      end
      wr(IDX_SECOND_GAIN, 32'h3f);
      tick(2);
      chk(32'(stage_b_code), 32'h2f, "second ignored");
      wr(IDX_GAIN_MODE, 32'h1);
      tick(2);
      chk(32'(stage_b_code), 32'h3f, "second used");
      apb(1'b1, 8'h13, 32'h1, rd, err);
      chk(32'(err), 32'h1, "unmapped error");
      // A reset in mid-run must restore the drive, column offset and second gain registers
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      tick(2);
      rchk(IDX_OUT_DRIVE, 32'h03);
      rchk(IDX_COL_OFFSET, 32'h00);
      rchk(IDX_SECOND_GAIN, 32'h0e);
      results;
   end

   // Tests need under two hundred cycles; this limit leaves wide margin
   initial
   begin
      tick(5000);
      fail_count++;
      results;
   end
endmodule
